// *** core/floppy_host_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface floppy_host_bus_if;
  import floppy_status_pkg::*;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data;
  logic host_data_oe_n;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe_n;
  logic [DATA_W-1:0] bus_data;
  // Pulled-up bus; device wins only if both drive, which is a host fault
  assign bus_data = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : IDLE_BUS_LEVEL);
  modport device (
    input cs_n, rd_n, wr_n, addr, bus_data,
    output dev_data, dev_data_oe_n
  );
  modport host (
    output cs_n, rd_n, wr_n, addr, host_data, host_data_oe_n,
    input bus_data
  );
endinterface
`default_nettype wire

// *** core/floppy_status_device.sv ***
// What this block does
// - Drive status bit 7 always reads zero
// - Write protect shown in bits 6, 3
// - Bit 5 always one, drive ready
// - Track-zero level in bit 4
// - Head side output in bit 2
// - Unit selects in bits 1, 0
// - Register A read at address 000
// - Later mode A: live, some inverted
// - Earlier mode A: live plus step flop
// - Step flop: pulse sets, read of address 111 clears
// - Register B read at address 100
// - Later B: read/write data toggle bits
// - Later B: motors, write enable, select
// - Earlier B: three event flops, read clears
// - Earlier B: motor-qualified selects, bit7 zero
// - Eight-bit command and result data register
// - Main status read decode
// - Data register read and write decode
`timescale 1ns/1ps
`default_nettype none
module floppy_status_device
  import floppy_status_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  floppy_host_bus_if.device bus,
  input wire logic mode_earlier_in,
  input wire logic direction_in,
  input wire logic write_protect_in,
  input wire logic index_in,
  input wire logic track_zero_in,
  input wire logic second_drive_installed_in,
  input wire logic head_side_flag_in,
  input wire logic unit_select_hi_in,
  input wire logic unit_select_lo_in,
  input wire logic step_pulse_in,
  input wire logic dma_request_in,
  input wire logic interrupt_in,
  input wire logic write_enable_in,
  input wire logic read_data_pulse_in,
  input wire logic write_data_pulse_in,
  input wire logic [DATA_W-1:0] digital_output_latch_in,
  input wire logic [DATA_W-1:0] main_status_in,
  input wire logic result_load_in,
  input wire logic [DATA_W-1:0] result_byte_in,
  output logic [DATA_W-1:0] drive_status_out,
  output logic [DATA_W-1:0] data_reg_out,
  output logic command_written_out,
  output logic result_taken_out
);
  import floppy_status_pkg::*;

  typedef struct packed {
    logic mode_earlier;
    logic step_flag;
    logic we_flag;
    logic rd_flag;
    logic wd_flag;
    logic rd_toggle;
    logic wd_toggle;
    logic read_active;
    logic write_active;
    logic [2:0] read_addr;
    logic [DATA_W-1:0] read_data;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] drive_status;
    logic command_written;
    logic result_taken;
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;
  logic selected;
  logic read_req;
  logic write_req;
  logic read_decoded;
  logic read_end;
  logic [DATA_W-1:0] aux_a;
  logic [DATA_W-1:0] aux_b;
  logic [DATA_W-1:0] status_byte;
  logic [DATA_W-1:0] read_mux;
  logic sel_code0;
  logic sel_code1;
  logic sel_code2;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  assign selected = !bus.cs_n;
  assign read_req = selected && !bus.rd_n && bus.wr_n;
  assign write_req = selected && !bus.wr_n && bus.rd_n && (bus.addr == ADDR_DATA);
  assign read_decoded = read_req && ((bus.addr == ADDR_AUX_A) || (bus.addr == ADDR_AUX_B)
    || (bus.addr == ADDR_MAIN_STATUS) || (bus.addr == ADDR_DATA));
  // Clear-on-read acts at strobe release so the byte stays stable
  assign read_end = state_reg.read_active && !read_req;

  ////////////////////////////////////////////////////////////////////////
  // Status layouts
  always_comb
  begin
    status_byte = '0;
    status_byte[DS_ZERO_BIT] = 1'b0;
    status_byte[DS_WP_HI_BIT] = write_protect_in;
    status_byte[DS_WP_LO_BIT] = write_protect_in;
    status_byte[DS_READY_BIT] = 1'b1;
    status_byte[DS_TRACK0_BIT] = track_zero_in;
    status_byte[DS_HEAD_BIT] = head_side_flag_in;
    status_byte[DS_US_HI_BIT] = unit_select_hi_in;
    status_byte[DS_US_LO_BIT] = unit_select_lo_in;
  end

  assign sel_code0 = digital_output_latch_in[1:0] == 2'h0;
  assign sel_code1 = digital_output_latch_in[1:0] == 2'h1;
  assign sel_code2 = digital_output_latch_in[1:0] == 2'h2;

  always_comb
  begin
    if (state_reg.mode_earlier == MODE_EARLIER)
    begin
      aux_a = {interrupt_in, dma_request_in, state_reg.step_flag, track_zero_in,
        head_side_flag_in, index_in, write_protect_in, direction_in};
      aux_b = {1'b0,
        sel_code1 && digital_output_latch_in[DOL_MOTOR1_BIT],
        sel_code0 && digital_output_latch_in[DOL_MOTOR0_BIT],
        state_reg.wd_flag, state_reg.rd_flag, state_reg.we_flag,
        1'b0,
        sel_code2 && digital_output_latch_in[DOL_MOTOR2_BIT]};
    end
    else
    begin
      aux_a = {interrupt_in, !second_drive_installed_in, step_pulse_in, !track_zero_in,
        head_side_flag_in, !index_in, !write_protect_in, direction_in};
      // Motors, write enable, select bit 0
      aux_b = {AUX_B_LATER_RSVD, digital_output_latch_in[DOL_SEL0_BIT],
        state_reg.wd_toggle, state_reg.rd_toggle, write_enable_in,
        digital_output_latch_in[DOL_MOTOR1_BIT], digital_output_latch_in[DOL_MOTOR0_BIT]};
    end
  end

  always_comb
  begin
    case (bus.addr)
      ADDR_AUX_A: read_mux = aux_a;
      ADDR_AUX_B: read_mux = aux_b;
      ADDR_MAIN_STATUS: read_mux = main_status_in;
      ADDR_DATA: read_mux = state_reg.data_reg;
      default: read_mux = IDLE_BUS_LEVEL;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_next = state_reg;
    // Mode is a strap; held stable so sampling each cycle is harmless
    state_next.mode_earlier = mode_earlier_in;
    state_next.command_written = 1'b0;
    state_next.result_taken = 1'b0;
    state_next.drive_status = status_byte;
    state_next.read_active = read_req;
    state_next.write_active = write_req;
    if (read_req)
    begin
      state_next.read_addr = bus.addr;
    end
    if (read_decoded)
    begin
      state_next.read_data = read_mux;
    end
    if (read_end && (state_reg.read_addr == ADDR_STEP_CLEAR))
    begin
      state_next.step_flag = 1'b0;
    end
    if (step_pulse_in)
    begin
      state_next.step_flag = 1'b1;
    end
    if (read_end && (state_reg.read_addr == ADDR_FLAGS_CLEAR))
    begin
      state_next.we_flag = 1'b0;
      state_next.rd_flag = 1'b0;
      state_next.wd_flag = 1'b0;
    end
    if (write_enable_in)
    begin
      state_next.we_flag = 1'b1;
    end
    if (read_data_pulse_in)
    begin
      state_next.rd_flag = 1'b1;
    end
    if (write_data_pulse_in)
    begin
      state_next.wd_flag = 1'b1;
    end
    if (read_data_pulse_in)
    begin
      state_next.rd_toggle = !state_reg.rd_toggle;
    end
    if (write_data_pulse_in)
    begin
      state_next.wd_toggle = !state_reg.wd_toggle;
    end
    if (write_req && !state_reg.write_active)
    begin
      state_next.data_reg = bus.bus_data;
      state_next.command_written = 1'b1;
    end
    else if (result_load_in)
    begin
      state_next.data_reg = result_byte_in;
    end
    if (read_end && (state_reg.read_addr == ADDR_DATA))
    begin
      state_next.result_taken = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= '0;
    end
    else if (clk_en_in)
    begin
      state_reg <= state_next;
    end
  end

  assign bus.dev_data_oe_n = !read_decoded;
  assign bus.dev_data = state_reg.read_data;
  assign drive_status_out = state_reg.drive_status;
  assign data_reg_out = state_reg.data_reg;
  assign command_written_out = state_reg.command_written;
  assign result_taken_out = state_reg.result_taken;
endmodule
`default_nettype wire

// *** core/floppy_status_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module floppy_status_host
  import floppy_status_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  floppy_host_bus_if.host bus,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out
);
  import floppy_status_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } host_phase_t;

  typedef struct packed {
    host_phase_t phase;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [3:0] count;
    logic done;
  } host_state_t;

  host_state_t state_reg;
  host_state_t state_next;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: one access at a time, address set up before the strobe
  always_comb
  begin
    state_next = state_reg;
    state_next.done = 1'b0;
    case (state_reg.phase)
      ST_IDLE:
      begin
        if (req_valid_in)
        begin
          state_next.write = req_write_in;
          state_next.addr = req_addr_in;
          state_next.wdata = req_wdata_in;
          state_next.phase = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        state_next.count = STROBE_COUNT;
        state_next.phase = ST_STROBE;
      end
      ST_STROBE:
      begin
        state_next.count = state_reg.count - 4'h1;
        if (state_reg.count == 4'h1)
        begin
          // Sample late in the strobe; device data lags one cycle
          state_next.rdata = state_reg.write ? state_reg.rdata : bus.bus_data;
          state_next.phase = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        state_next.done = 1'b1;
        state_next.phase = ST_IDLE;
      end
      default:
      begin
        state_next.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= '0;
    end
    else if (clk_en_in)
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins
  assign bus.cs_n = state_reg.phase == ST_IDLE;
  assign bus.addr = state_reg.addr;
  assign bus.rd_n = !((state_reg.phase == ST_STROBE) && !state_reg.write);
  assign bus.wr_n = !((state_reg.phase == ST_STROBE) && state_reg.write);
  assign bus.host_data = state_reg.wdata;
  // Data held through hold phase so the device sees it past strobe release
  assign bus.host_data_oe_n = !(state_reg.write && (state_reg.phase != ST_IDLE));
  assign req_ready_out = state_reg.phase == ST_IDLE;
  assign done_out = state_reg.done;
  assign rdata_out = state_reg.rdata;
endmodule
`default_nettype wire

// *** core/floppy_status_pkg.sv ***
`default_nettype none
package floppy_status_pkg;
  // Host bus widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Port decode, value is {A2, A1, A0}
  localparam logic [2:0] ADDR_AUX_A = 3'h0;
  localparam logic [2:0] ADDR_MAIN_STATUS = 3'h1;
  localparam logic [2:0] ADDR_AUX_B = 3'h4;
  localparam logic [2:0] ADDR_DATA = 3'h5;
  localparam logic [2:0] ADDR_INPUT_PORT = 3'h7;
  // Reads that clear the earlier-model event flops
  localparam logic [2:0] ADDR_STEP_CLEAR = ADDR_INPUT_PORT;
  localparam logic [2:0] ADDR_FLAGS_CLEAR = ADDR_AUX_B;
  // Compatibility modes
  localparam logic MODE_LATER = 1'b0;
  localparam logic MODE_EARLIER = 1'b1;
  // Drive status byte fields
  localparam int DS_ZERO_BIT = 7;
  localparam int DS_WP_HI_BIT = 6;
  localparam int DS_READY_BIT = 5;
  localparam int DS_TRACK0_BIT = 4;
  localparam int DS_WP_LO_BIT = 3;
  localparam int DS_HEAD_BIT = 2;
  localparam int DS_US_HI_BIT = 1;
  localparam int DS_US_LO_BIT = 0;
  // Output latch fields
  localparam int DOL_SEL0_BIT = 0;
  localparam int DOL_SEL1_BIT = 1;
  localparam int DOL_MOTOR0_BIT = 4;
  localparam int DOL_MOTOR1_BIT = 5;
  localparam int DOL_MOTOR2_BIT = 6;
  // Fixed values
  localparam logic [1:0] AUX_B_LATER_RSVD = 2'h3;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] IDLE_BUS_LEVEL = 8'hFF;
  // Host timing, 10 ns clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 30;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_COUNT = 4'(STROBE_CYCLES);
endpackage
`default_nettype wire

// *** testbench/floppy_host_bus_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module floppy_host_bus_monitor
  import floppy_status_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] host_data_in,
  input wire logic host_data_oe_n_in,
  input wire logic [DATA_W-1:0] dev_data_in,
  input wire logic dev_data_oe_n_in,
  input wire logic [DATA_W-1:0] bus_data_in
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic dec_rd;
  assign dec_rd = !cs_n_in && !rd_n_in && wr_n_in
    && (addr_in inside {ADDR_AUX_A, ADDR_MAIN_STATUS, ADDR_AUX_B, ADDR_DATA});
  ////////////////////////////////////////////////////////////////
  // Strobe low for three cycles, then up
  sequence s_strobe3(logic s);
    !s [*3] ##1 s;
  endsequence
  // Select settles a cycle before any strobe
  sequence s_setup;
    (!cs_n_in && rd_n_in && wr_n_in) ##1 (!cs_n_in && (!rd_n_in || !wr_n_in));
  endsequence
  ////////////////////////////////////////////////////////////////
  a_oe_on_decode: assert property (dev_data_oe_n_in == !dec_rd)
    else $error("device bus enable does not match read decode");
  // Both ends driving at once would be a bus fight
  a_read_resolves: assert property (!dev_data_oe_n_in |-> host_data_oe_n_in && bus_data_in == dev_data_in)
    else $error("bus does not carry device byte alone in read");
  a_write_drives: assert property (!cs_n_in && !wr_n_in |-> !host_data_oe_n_in && bus_data_in == host_data_in)
    else $error("host byte not on bus during write strobe");
  a_read_len: assert property ($fell(rd_n_in) |-> s_strobe3(rd_n_in))
    else $error("read strobe length wrong");
  a_write_len: assert property ($fell(wr_n_in) |-> s_strobe3(wr_n_in))
    else $error("write strobe length wrong");
  a_setup_first: assert property ($fell(cs_n_in) |-> s_setup)
    else $error("strobe without setup cycle");
  a_hold_release: assert property ($rose(rd_n_in) || $rose(wr_n_in) |-> !cs_n_in ##1 cs_n_in)
    else $error("select not held one cycle after strobe");
  a_addr_steady: assert property (!cs_n_in && !$past(cs_n_in) |-> $stable(addr_in))
    else $error("address moved during access");
endmodule
`default_nettype wire

// *** testbench/floppy_host_status_ports_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) cmp(n, e, g);
module floppy_host_status_ports_test;
  import floppy_status_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic rl = 1'b0;
  logic rv = 1'b0;
  logic rw = 1'b0;
  logic [2:0] ra = 3'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] dol = 8'h00;
  logic [7:0] mst = 8'h00;
  logic [7:0] rb = 8'h00;
  logic [7:0] w8;
  // Live inputs: irq dma usl ush hs sdi t0 idx wp dir
  logic [9:0] lv = 10'h000;
  // Events: write data, read data, write enable, step
  logic [3:0] ev = 4'h0;
  logic rdy, done, cw, rt;
  logic [7:0] rdata, ds, dreg;
  logic [9:0] got_e;
  logic [2:0] unm [4] = '{3'h2, 3'h3, 3'h6, 3'h7};
  int err_total = 0;
  int check_count = 0;
  // Note is {result taken, read, byte}
  logic [9:0] exp_q [$];
  logic [7:0] wr_q [$];
  floppy_host_bus_if floppy_host_bus_if_i ();
  floppy_status_device floppy_status_device_i (.sys_clk_in(clk), .rst_n_in(rst_n),
    .clk_en_in(1'b1), .bus(floppy_host_bus_if_i), .mode_earlier_in(mode),
    .direction_in(lv[0]), .write_protect_in(lv[1]), .index_in(lv[2]),
    .track_zero_in(lv[3]), .second_drive_installed_in(lv[4]), .head_side_flag_in(lv[5]),
    .unit_select_hi_in(lv[6]), .unit_select_lo_in(lv[7]), .step_pulse_in(ev[0]),
    .dma_request_in(lv[8]), .interrupt_in(lv[9]), .write_enable_in(ev[1]),
    .read_data_pulse_in(ev[2]), .write_data_pulse_in(ev[3]),
    .digital_output_latch_in(dol), .main_status_in(mst), .result_load_in(rl),
    .result_byte_in(rb), .drive_status_out(ds), .data_reg_out(dreg),
    .command_written_out(cw), .result_taken_out(rt));
  floppy_status_host floppy_status_host_i (.sys_clk_in(clk), .rst_n_in(rst_n),
    .clk_en_in(1'b1), .bus(floppy_host_bus_if_i), .req_valid_in(rv), .req_write_in(rw),
    .req_addr_in(ra), .req_wdata_in(wd), .req_ready_out(rdy), .done_out(done),
    .rdata_out(rdata));
  floppy_host_bus_monitor floppy_host_bus_monitor_i (.sys_clk_in(clk), .rst_n_in(rst_n),
    .cs_n_in(floppy_host_bus_if_i.cs_n), .rd_n_in(floppy_host_bus_if_i.rd_n),
    .wr_n_in(floppy_host_bus_if_i.wr_n), .addr_in(floppy_host_bus_if_i.addr),
    .host_data_in(floppy_host_bus_if_i.host_data),
    .host_data_oe_n_in(floppy_host_bus_if_i.host_data_oe_n),
    .dev_data_in(floppy_host_bus_if_i.dev_data),
    .dev_data_oe_n_in(floppy_host_bus_if_i.dev_data_oe_n),
    .bus_data_in(floppy_host_bus_if_i.bus_data));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_ds();
    return {1'b0, lv[1], 1'b1, lv[3], lv[1], lv[5], lv[6], lv[7]};
  endfunction
  function automatic logic [7:0] exp_a(input logic sf);
    if (mode)
      return {lv[9], lv[8], sf, lv[3], lv[5], lv[2], lv[1], lv[0]};
    return {lv[9], ~lv[4], ev[0], ~lv[3], lv[5], ~lv[2], ~lv[1], lv[0]};
  endfunction
  // Earlier flags {wd, rd, we}; later {wd toggle, rd toggle, unused}
  function automatic logic [7:0] exp_b(input logic [2:0] f);
    if (mode)
      return {1'b0, dol[1:0] == 2'h1 && dol[5], dol[1:0] == 2'h0 && dol[4], f, 1'b0,
        dol[1:0] == 2'h2 && dol[6]};
    return {2'b11, dol[0], f[2], f[1], ev[1], dol[5], dol[4]};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Next request only after done, so it is always taken
  task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    int n;
    @(posedge clk);
    rv <= 1'b1;
    rw <= w;
    ra <= a;
    wd <= d;
    exp_q.push_back({!w && a == ADDR_DATA, !w, e});
    if (w && a == ADDR_DATA)
      wr_q.push_back(d);
    @(posedge clk);
    rv <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 20)
      err_total++;
  endtask
  task automatic pulse(input logic [3:0] m, input int k);
    @(posedge clk);
    ev <= m;
    repeat (k) @(posedge clk);
    ev <= 4'h0;
  endtask
  task automatic rnd();
    @(posedge clk);
    lv <= 10'($urandom);
    dol <= 8'($urandom);
    mst <= 8'($urandom);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(negedge clk)
  begin
    if (done === 1'b1)
    begin
      got_e = exp_q.pop_front();
      `CHK("req_ready", 8'h01, 8'(rdy))
      `CHK("result_taken", 8'(got_e[9]), 8'(rt))
      if (got_e[8]) `CHK("rdata", got_e[7:0], rdata)
    end
    if (cw === 1'b1) `CHK("data_reg", wr_q.pop_front(), dreg)
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(98057));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6)
    begin
      rnd();
      @(negedge clk);
      `CHK("drive_status", exp_ds(), ds)
      op(1'b0, ADDR_AUX_A, 8'h00, exp_a(1'b0));
      op(1'b0, ADDR_MAIN_STATUS, 8'h00, mst);
    end
    // Toggle bits flip once per cycle that the pulse input is high
    pulse(4'h4, 3);
    pulse(4'h8, 2);
    op(1'b0, ADDR_AUX_B, 8'h00, exp_b(3'b010));
    pulse(4'h8, 1);
    op(1'b0, ADDR_AUX_B, 8'h00, exp_b(3'b110));
    repeat (3)
    begin
      w8 = 8'($urandom);
      op(1'b1, ADDR_DATA, w8, 8'h00);
      op(1'b1, ADDR_AUX_B, ~w8, 8'h00);
      op(1'b0, ADDR_DATA, 8'h00, w8);
    end
    foreach (unm[i]) op(1'b0, unm[i], 8'h00, IDLE_BUS_LEVEL);
    @(posedge clk);
    rb <= 8'($urandom);
    rl <= 1'b1;
    @(posedge clk);
    rl <= 1'b0;
    op(1'b0, ADDR_DATA, 8'h00, rb);
    // Second reset clears state before the mode swap
    @(posedge clk);
    rst_n <= 1'b0;
    mode <= MODE_EARLIER;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rnd();
    pulse(4'h1, 1);
    op(1'b0, ADDR_AUX_A, 8'h00, exp_a(1'b1));
    op(1'b0, ADDR_INPUT_PORT, 8'h00, IDLE_BUS_LEVEL);
    op(1'b0, ADDR_AUX_A, 8'h00, exp_a(1'b0));
    for (int k = 0; k < 3; k++)
    begin
      rnd();
      pulse(4'(2 << k), 1);
      op(1'b0, ADDR_AUX_B, 8'h00, exp_b(3'(1 << k)));
      op(1'b0, ADDR_AUX_B, 8'h00, exp_b(3'b000));
    end
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
